//--- src/cte_core.sv
// Execute unit for data transfer, shift, bit and flag instructions.
// Assumes decoded instructions on ins, memories answering in the cycle
// their strobe is high, and a program-memory writer reporting done.
//
// Overview of operation
// - With interrupts enabled, branch to PC+k+1; 1 cycle untaken, 2 taken.
// - With interrupts disabled, branch to PC+k+1; 1 or 2 cycles, flags kept.
// - Pointer fetch reads at pointer then adds one to it; 2 cycles.
// - Pointer fetch first subtracts one, then reads new address; 2 cycles.
// - Offset fetch reads at Y or Z plus q, pointer kept; 2 cycles.
// - Direct fetch reads at address k; 2 cycles, flags kept.
// - Pointer write stores at pointer then increments it; 2 cycles.
// - Pointer write decrements pointer before storing; 2 cycles.
// - Offset write stores at Y or Z plus q, pointer kept; 2 cycles.
// - Direct write stores at address k; 2 cycles, flags kept.
// - Code fetch reads program byte at Z into R0 or Rd, optional Z+1; 3 cycles.
// - Stack save pushes source register in 2 cycles, flags kept.
// - Stack restore pops into destination in 2 cycles, flags kept.
// - I/O bit raise or drop forces bit b of the port; 2 cycles.
// - Rotate up through carry, old bit 7 to carry, Z C N V updated.
// - Rotate down through carry, old bit 0 to carry, Z C N V updated.
// - T capture copies bit b of source into T in 1 cycle.
// - T deposit writes T into bit b of destination, flags kept.
// - Named single-cycle ops set or clear one status flag only.
// - Raise-any and drop-any change only status bit s in 1 cycle.
module cte_core (
  input  logic                mclk,
  input  logic                rst,
  input  logic                ins_valid,
  input  cte_pkg::cte_instr_s ins,
  output logic                ins_ready,
  output logic [15:0]         pc,
  output logic [7:0]          status_flags,
  output logic [15:0]         sp,
  output cte_pkg::cte_dmem_s  dmem,
  input  logic [7:0]          dmem_rdata,
  output cte_pkg::cte_io_s    io,
  input  logic [7:0]          io_rdata,
  output cte_pkg::cte_pmem_s  pmem,
  input  logic [7:0]          pmem_rdata,
  input  logic                pmem_done,
  input  logic [4:0]          dbg_sel,
  output logic [7:0]          dbg_data
);
  import cte_pkg::*;

  cte_state_s       s_r;
  cte_state_s       s_nxt;
  logic [31:0][7:0] rfv;
  logic [4:0]       plo;
  logic [4:0]       phi;
  logic [15:0]      pv;
  logic [15:0]      pa;
  logic [15:0]      pw;
  logic             wr_ptr;
  logic [15:0]      zv;
  logic [15:0]      br_tgt;
  logic [7:0]       v;
  logic [7:0]       res;
  logic             cy;
  logic             sh;
  logic [7:0]       fl;
  logic             acc;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register
  assign ins_ready = s_r.ready;
  assign pc        = s_r.pc;
  assign status_flags      = s_r.status_flags;
  assign sp        = s_r.sp;
  assign dmem      = s_r.dmem;
  assign io        = s_r.io;
  assign pmem      = s_r.pmem;
  assign dbg_data  = s_r.dbg;
  assign acc       = ins_valid && s_r.ready;

  // Operand views; a port read still in flight is forwarded so it costs no stall
  always_comb begin
    rfv = s_r.rf;
    if (s_r.pend) begin
      rfv[s_r.dst] = io_rdata;
    end
    plo    = PTR_LO_BASE + {2'b00, ins.ptr, 1'b0};
    phi    = plo + 5'h01;
    pv     = {rfv[phi], rfv[plo]};
    zv     = {rfv[Z_HI], rfv[Z_LO]};
    br_tgt = s_r.pc + PC_STEP + {{9{ins.k[6]}}, ins.k[6:0]};
    v      = rfv[ins.rd];
  end

  // Pointer address modes shared by pointer fetch and write
  always_comb begin
    pa     = pv;
    pw     = pv;
    wr_ptr = 1'b0;
    case (ins.amode)
      AM_POSTINC: begin
        pw     = pv + 16'h0001;
        wr_ptr = 1'b1;
      end
      AM_PREDEC: begin
        pa     = pv - 16'h0001;
        pw     = pv - 16'h0001;
        wr_ptr = 1'b1;
      end
      default: begin
        wr_ptr = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_nxt         = s_r;
    s_nxt.rf      = rfv;
    s_nxt.pend    = 1'b0;
    s_nxt.dmem.we = 1'b0;
    s_nxt.dmem.re = 1'b0;
    s_nxt.io.we   = 1'b0;
    s_nxt.io.re   = 1'b0;
    s_nxt.pmem.we = 1'b0;
    s_nxt.dbg     = rfv[dbg_sel];
    fl            = s_r.status_flags;
    res           = 8'h00;
    cy            = 1'b0;
    sh            = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (ins_valid) begin
          s_nxt.pc  = s_r.pc + PC_STEP;
          s_nxt.dst = ins.rd;
          case (ins.op)
            OP_BR_ION: begin
              if (s_r.status_flags[FLAG_I]) begin
                s_nxt.pc = br_tgt;
                s_nxt.st = ST_BUBBLE;
              end
            end
            OP_BR_IOFF: begin
              if (!s_r.status_flags[FLAG_I]) begin
                s_nxt.pc = br_tgt;
                s_nxt.st = ST_BUBBLE;
              end
            end
            OP_REG_COPY: s_nxt.rf[ins.rd] = rfv[ins.rr];
            OP_PAIR_COPY: begin
              s_nxt.rf[{ins.rd[4:1], 1'b0}] = rfv[{ins.rr[4:1], 1'b0}];
              s_nxt.rf[{ins.rd[4:1], 1'b1}] = rfv[{ins.rr[4:1], 1'b1}];
            end
            OP_IMM_LOAD: s_nxt.rf[ins.rd] = ins.k[7:0];
            OP_IND_FETCH, OP_IND_WRITE: begin
              s_nxt.dmem.addr  = pa;
              s_nxt.dmem.wdata = rfv[ins.rr];
              s_nxt.dmem.re    = (ins.op == OP_IND_FETCH);
              s_nxt.dmem.we    = (ins.op == OP_IND_WRITE);
              s_nxt.st         = (ins.op == OP_IND_FETCH) ? ST_DLOAD : ST_BUBBLE;
              if (wr_ptr) begin
                s_nxt.rf[plo] = pw[7:0];
                s_nxt.rf[phi] = pw[15:8];
              end
            end
            OP_OFS_FETCH, OP_OFS_WRITE: begin
              s_nxt.dmem.addr  = pv + {10'h000, ins.q};
              s_nxt.dmem.wdata = rfv[ins.rr];
              s_nxt.dmem.re    = (ins.op == OP_OFS_FETCH);
              s_nxt.dmem.we    = (ins.op == OP_OFS_WRITE);
              s_nxt.st         = (ins.op == OP_OFS_FETCH) ? ST_DLOAD : ST_BUBBLE;
            end
            OP_DIR_FETCH, OP_DIR_WRITE: begin
              // Two-word instructions step the program counter by two
              s_nxt.pc         = s_r.pc + PC_STEP2;
              s_nxt.dmem.addr  = ins.k;
              s_nxt.dmem.wdata = rfv[ins.rr];
              s_nxt.dmem.re    = (ins.op == OP_DIR_FETCH);
              s_nxt.dmem.we    = (ins.op == OP_DIR_WRITE);
              s_nxt.st         = (ins.op == OP_DIR_FETCH) ? ST_DLOAD : ST_BUBBLE;
            end
            OP_CODE_FETCH0, OP_CODE_FETCH: begin
              s_nxt.pmem.addr = zv;
              s_nxt.pmem.re   = 1'b1;
              s_nxt.dst       = (ins.op == OP_CODE_FETCH0) ? 5'h00 : ins.rd;
              s_nxt.st        = ST_PWAIT;
              if (ins.op == OP_CODE_FETCH && ins.amode == AM_POSTINC) begin
                s_nxt.rf[Z_LO] = zv[7:0] + 8'h01;
                s_nxt.rf[Z_HI] = zv[15:8] + {7'h00, (zv[7:0] == 8'hFF)};
              end
            end
            OP_CODE_WRITE: begin
              s_nxt.pmem.addr  = zv;
              s_nxt.pmem.wdata = {rfv[1], rfv[0]};
              s_nxt.pmem.we    = 1'b1;
              s_nxt.st         = ST_CWRITE;
            end
            OP_IO_READ: begin
              s_nxt.io.addr = ins.k[5:0];
              s_nxt.io.re   = 1'b1;
              s_nxt.pend    = 1'b1;
            end
            OP_IO_WRITE: begin
              s_nxt.io.addr  = ins.k[5:0];
              s_nxt.io.wdata = rfv[ins.rr];
              s_nxt.io.we    = 1'b1;
            end
            OP_STACK_SAVE: begin
              s_nxt.dmem.addr  = s_r.sp;
              s_nxt.dmem.wdata = rfv[ins.rr];
              s_nxt.dmem.we    = 1'b1;
              s_nxt.sp         = s_r.sp - 16'h0001;
              s_nxt.st         = ST_BUBBLE;
            end
            OP_STACK_RESTORE: begin
              s_nxt.dmem.addr = s_r.sp + 16'h0001;
              s_nxt.dmem.re   = 1'b1;
              s_nxt.sp        = s_r.sp + 16'h0001;
              s_nxt.st        = ST_DLOAD;
            end
            OP_IO_BIT_RAISE, OP_IO_BIT_DROP: begin
              // Read-modify-write of the port; the write is posted in cycle 2
              s_nxt.io.addr = ins.k[5:0];
              s_nxt.io.re   = 1'b1;
              s_nxt.bsel    = ins.b;
              s_nxt.flag_raise_any    = (ins.op == OP_IO_BIT_RAISE);
              s_nxt.st      = ST_IORMW;
            end
            OP_SHIFT_UP: begin
              res = {v[6:0], 1'b0};
              cy  = v[7];
              sh  = 1'b1;
            end
            OP_SHIFT_DOWN: begin
              res = {1'b0, v[7:1]};
              cy  = v[0];
              sh  = 1'b1;
            end
            OP_SIGN_DOWN: begin
              res = {v[7], v[7:1]};
              cy  = v[0];
              sh  = 1'b1;
            end
            OP_ROT_UP: begin
              res = {v[6:0], s_r.status_flags[FLAG_C]};
              cy  = v[7];
              sh  = 1'b1;
            end
            OP_ROT_DOWN: begin
              res = {s_r.status_flags[FLAG_C], v[7:1]};
              cy  = v[0];
              sh  = 1'b1;
            end
            OP_NIBBLE_EXCH: s_nxt.rf[ins.rd] = {v[3:0], v[7:4]};
            OP_FLAG_RAISE_ANY: fl[ins.s] = 1'b1;
            OP_FLAG_DROP_ANY:  fl[ins.s] = 1'b0;
            OP_T_CAPTURE: fl[FLAG_T] = rfv[ins.rr][ins.b];
            OP_T_DEPOSIT: s_nxt.rf[ins.rd][ins.b] = s_r.status_flags[FLAG_T];
            OP_CARRY_RAISE:  fl[FLAG_C] = 1'b1;
            OP_CARRY_DROP:   fl[FLAG_C] = 1'b0;
            OP_ZERO_RAISE:   fl[FLAG_Z] = 1'b1;
            OP_ZERO_DROP:    fl[FLAG_Z] = 1'b0;
            OP_NEG_RAISE:    fl[FLAG_N] = 1'b1;
            OP_NEG_DROP:     fl[FLAG_N] = 1'b0;
            OP_OVF_RAISE:    fl[FLAG_V] = 1'b1;
            OP_OVF_DROP:     fl[FLAG_V] = 1'b0;
            OP_SIGN_RAISE:   fl[FLAG_S] = 1'b1;
            OP_SIGN_DROP:    fl[FLAG_S] = 1'b0;
            OP_HALF_RAISE:   fl[FLAG_H] = 1'b1;
            OP_HALF_DROP:    fl[FLAG_H] = 1'b0;
            OP_TFLAG_RAISE:  fl[FLAG_T] = 1'b1;
            OP_TFLAG_DROP:   fl[FLAG_T] = 1'b0;
            OP_IRQ_ON:       fl[FLAG_I] = 1'b1;
            OP_IRQ_OFF:      fl[FLAG_I] = 1'b0;
            default: begin
              sh = 1'b0;
            end
          endcase
          // Shift results and their four flags; sign flag is left alone
          if (sh) begin
            s_nxt.rf[ins.rd] = res;
            fl[FLAG_C]       = cy;
            fl[FLAG_Z]       = (res == 8'h00);
            fl[FLAG_N]       = res[7];
            fl[FLAG_V]       = res[7] ^ cy;
          end
        end
      end
      ST_DLOAD: begin
        s_nxt.rf[s_r.dst] = dmem_rdata;
        s_nxt.st          = ST_IDLE;
      end
      ST_IORMW: begin
        s_nxt.io.wdata          = io_rdata;
        s_nxt.io.wdata[s_r.bsel] = s_r.flag_raise_any;
        s_nxt.io.we             = 1'b1;
        s_nxt.st                = ST_IDLE;
      end
      ST_PWAIT: s_nxt.st = ST_PLOAD;
      ST_PLOAD: begin
        s_nxt.rf[s_r.dst] = pmem_rdata;
        s_nxt.pmem.re     = 1'b0;
        s_nxt.st          = ST_IDLE;
      end
      ST_CWRITE: begin
        // No fixed length: the writer holds us until it reports done
        if (pmem_done) begin
          s_nxt.st = ST_IDLE;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    s_nxt.status_flags  = fl;
    s_nxt.ready = (s_nxt.st == ST_IDLE);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.pc    <= PC_RESET;
      s_r.sp    <= SP_RESET;
      s_r.status_flags  <= STATUS_FLAGS_RESET;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_one_busy;
    !ins_ready ##1 ins_ready;
  endsequence

  sequence s_two_busy;
    (!ins_ready && pmem.re)[*2] ##1 ins_ready;
  endsequence

  a_branch_on_taken: assert property (
    acc && ins.op == OP_BR_ION && status_flags[FLAG_I]
    |=> pc == $past(br_tgt) && status_flags == $past(status_flags) ##0 s_one_busy)
    else $error("taken branch on irq set wrong target or length");

  a_branch_off_skip: assert property (
    acc && ins.op == OP_BR_IOFF && status_flags[FLAG_I]
    |=> ins_ready && pc == $past(pc) + PC_STEP)
    else $error("untaken branch on irq clear did not fall through");

  a_fetch_two_cycle: assert property (
    acc && ins.op inside {OP_IND_FETCH, OP_OFS_FETCH, OP_DIR_FETCH, OP_STACK_RESTORE}
    |=> dmem.re && status_flags == $past(status_flags) ##0 s_one_busy)
    else $error("data fetch not two cycles or flags moved");

  a_fetch_predec_addr: assert property (
    acc && ins.op == OP_IND_FETCH && ins.amode == AM_PREDEC
    |=> dmem.addr == $past(pv) - 16'h0001)
    else $error("pre-decrement fetch used the old pointer");

  a_write_two_cycle: assert property (
    acc && ins.op inside {OP_IND_WRITE, OP_OFS_WRITE, OP_DIR_WRITE, OP_STACK_SAVE}
    |=> dmem.we && dmem.wdata == $past(rfv[ins.rr]) ##0 s_one_busy)
    else $error("data write not two cycles or wrong data");

  a_code_fetch_len: assert property (
    acc && ins.op inside {OP_CODE_FETCH0, OP_CODE_FETCH} |=> s_two_busy)
    else $error("code fetch did not take three cycles");

  a_io_bit_rmw: assert property (
    acc && ins.op == OP_IO_BIT_RAISE
    |=> io.re ##1 io.we && io.wdata[$past(ins.b, 2)] && ins_ready)
    else $error("io bit raise did not write a one");

  a_rotate_up_carry: assert property (
    acc && ins.op == OP_ROT_UP |=> status_flags[FLAG_C] == $past(v[7]) && ins_ready)
    else $error("rotate up lost bit 7 into carry");

  a_rotate_down_carry: assert property (
    acc && ins.op == OP_ROT_DOWN |=> status_flags[FLAG_C] == $past(v[0]))
    else $error("rotate down lost bit 0 into carry");

  a_t_capture_bit: assert property (
    acc && ins.op == OP_T_CAPTURE
    |=> status_flags[FLAG_T] == $past(rfv[ins.rr][ins.b]) && status_flags[5:0] == $past(status_flags[5:0]))
    else $error("transfer flag capture wrong");

  a_flag_any_only: assert property (
    acc && ins.op == OP_FLAG_DROP_ANY
    |=> status_flags == ($past(status_flags) & ~(8'h01 << $past(ins.s))))
    else $error("flag drop touched other bits");
endmodule : cte_core

//--- include/cte_pkg.sv
// Types and constants of the transfer, bit and flag execute unit.
// Assumes one clock domain and an external decoder filling cte_instr_s.
package cte_pkg;
  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  // Pointer pairs: X=27:26, Y=29:28, Z=31:30
  localparam logic [4:0] PTR_LO_BASE = 5'h1A;
  localparam logic [4:0] Z_LO        = 5'h1E;
  localparam logic [4:0] Z_HI        = 5'h1F;
  // Values after reset, and program counter steps
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] SP_RESET   = 16'h00FF;
  localparam logic [7:0]  STATUS_FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_STEP    = 16'h0001;
  localparam logic [15:0] PC_STEP2   = 16'h0002;

  typedef enum logic [1:0] {
    AM_PLAIN = 2'b00, AM_POSTINC = 2'b01, AM_PREDEC = 2'b10
  } cte_amode_e;

  typedef enum logic [5:0] {
    OP_NOP = 6'b000000, OP_BR_ION = 6'b000001, OP_BR_IOFF = 6'b000010,
    OP_REG_COPY = 6'b000011, OP_PAIR_COPY = 6'b000100, OP_IMM_LOAD = 6'b000101,
    OP_IND_FETCH = 6'b000110, OP_OFS_FETCH = 6'b000111, OP_DIR_FETCH = 6'b001000,
    OP_IND_WRITE = 6'b001001, OP_OFS_WRITE = 6'b001010, OP_DIR_WRITE = 6'b001011,
    OP_CODE_FETCH0 = 6'b001100, OP_CODE_FETCH = 6'b001101, OP_CODE_WRITE = 6'b001110,
    OP_IO_READ = 6'b001111, OP_IO_WRITE = 6'b010000, OP_STACK_SAVE = 6'b010001,
    OP_STACK_RESTORE = 6'b010010, OP_IO_BIT_RAISE = 6'b010011, OP_IO_BIT_DROP = 6'b010100,
    OP_SHIFT_UP = 6'b010101, OP_SHIFT_DOWN = 6'b010110, OP_ROT_UP = 6'b010111,
    OP_ROT_DOWN = 6'b011000, OP_SIGN_DOWN = 6'b011001, OP_NIBBLE_EXCH = 6'b011010,
    OP_FLAG_RAISE_ANY = 6'b011011, OP_FLAG_DROP_ANY = 6'b011100,
    OP_T_CAPTURE = 6'b011101, OP_T_DEPOSIT = 6'b011110,
    OP_CARRY_RAISE = 6'b100000, OP_CARRY_DROP = 6'b100001,
    OP_ZERO_RAISE = 6'b100010, OP_ZERO_DROP = 6'b100011,
    OP_NEG_RAISE = 6'b100100, OP_NEG_DROP = 6'b100101,
    OP_OVF_RAISE = 6'b100110, OP_OVF_DROP = 6'b100111,
    OP_SIGN_RAISE = 6'b101000, OP_SIGN_DROP = 6'b101001,
    OP_HALF_RAISE = 6'b101010, OP_HALF_DROP = 6'b101011,
    OP_TFLAG_RAISE = 6'b101100, OP_TFLAG_DROP = 6'b101101,
    OP_IRQ_ON = 6'b101110, OP_IRQ_OFF = 6'b101111
  } cte_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_DLOAD = 3'b001, ST_BUBBLE = 3'b010, ST_IORMW = 3'b011,
    ST_PWAIT = 3'b100, ST_PLOAD = 3'b101, ST_CWRITE = 3'b110
  } cte_state_e;

  typedef struct packed {
    cte_op_e    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [15:0] k;
    logic [5:0] q;
    logic [2:0] b;
    logic [2:0] s;
    logic [1:0] ptr;
    cte_amode_e amode;
  } cte_instr_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cte_dmem_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cte_io_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } cte_pmem_s;

  typedef struct packed {
    cte_state_e       st;
    logic [31:0][7:0] rf;
    logic [7:0]       status_flags;
    logic [15:0]      pc;
    logic [15:0]      sp;
    logic [4:0]       dst;
    logic             pend;
    logic [2:0]       bsel;
    logic             flag_raise_any;
    logic             ready;
    logic [7:0]       dbg;
    cte_dmem_s        dmem;
    cte_io_s          io;
    cte_pmem_s        pmem;
  } cte_state_s;
endpackage : cte_pkg

//--- testbench/tb.sv
// Self-checking bench for the transfer, bit and flag execute unit.
// Assumes the unit of cte_core alone; data, I/O and program memories are simple
// address-derived models in this bench, answering at the falling edge.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cte_pkg::*;

  logic        mclk, rst, ins_valid, ins_ready, pmem_done, done_d;
  cte_instr_s  ins;
  logic [15:0] pc, sp, ncyc, p;
  logic [7:0]  status_flags, dmem_rdata, io_rdata, pmem_rdata, dbg_data, v;
  logic [4:0]  dbg_sel;
  cte_dmem_s   dmem, dm_seen;
  cte_io_s     io, io_seen;
  cte_pmem_s   pmem, pm_seen;
  int          error_cnt, cmp_count;
  cte_op_e     sops [4] = '{OP_SIGN_DOWN, OP_SHIFT_DOWN, OP_SHIFT_UP, OP_NIBBLE_EXCH};
  logic [7:0]  sexp [4] = '{8'hC0, 8'h60, 8'hC0, 8'h0C};

  cte_core dut_u (.mclk(mclk), .rst(rst), .ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready),
    .pc(pc), .status_flags(status_flags), .sp(sp), .dmem(dmem), .dmem_rdata(dmem_rdata), .io(io), .io_rdata(io_rdata),
    .pmem(pmem), .pmem_rdata(pmem_rdata), .pmem_done(pmem_done), .dbg_sel(dbg_sel), .dbg_data(dbg_data));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Data memory content is derived from the address, so a wrong address shows unless its two bytes xor to the same value
  function automatic logic [7:0] dval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5C;
  endfunction : dval

  // Memory answers and strobe capture; program writer finishes two cycles after its pulse
  always @(negedge mclk) begin
    dmem_rdata <= dval(dmem.addr);
    io_rdata   <= {2'b00, io.addr} ^ 8'hC3;
    pmem_rdata <= dval(~pmem.addr);
    done_d     <= pmem.we;
    pmem_done  <= done_d;
    if (dmem.re || dmem.we) dm_seen <= dmem;
    if (pmem.re || pmem.we) pm_seen <= pmem;
  end

  // Port writes are caught as they appear, since a check may run at the very negedge of the pulse
  always @(io) begin
    if (io.we) io_seen = io;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // Offer one instruction at a falling edge, count cycles until ready again
  task automatic ex(input cte_op_e o, input logic [4:0] d = 5'h00, input logic [4:0] r = 5'h00,
                    input logic [15:0] kk = 16'h0000, input logic [5:0] qq = 6'h00,
                    input logic [2:0] bb = 3'h0, input logic [1:0] pp = 2'h0, input cte_amode_e am = AM_PLAIN);
    int n;
    n = 0;
    while (ins_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    ins = '{op: o, rd: d, rr: r, k: kk, q: qq, b: bb, s: bb, ptr: pp, amode: am};
    ins_valid = 1'b1;
    @(negedge mclk);
    ins_valid = 1'b0;
    ncyc = 16'h0001;
    while (ins_ready !== 1'b1 && ncyc < 16'h0032) begin
      @(negedge mclk);
      ncyc++;
    end
  endtask : ex

  // Register file read through the debug port, which lags one cycle
  task automatic gr(input logic [4:0] idx, output logic [7:0] val);
    dbg_sel = idx;
    repeat (2) @(negedge mclk);
    val = dbg_data;
  endtask : gr

  task automatic gp(input logic [4:0] lo, output logic [15:0] pv);
    logic [7:0] a, b;
    gr(lo, a);
    gr(lo + 5'h01, b);
    pv = {b, a};
  endtask : gp

  task automatic li(input logic [4:0] d, input logic [7:0] val);
    ex(OP_IMM_LOAD, d, 5'h00, {8'h00, val});
  endtask : li

  // Two-cycle data transfer with address, data, strobe and flag checks
  task automatic xf(input cte_op_e o, input logic [4:0] d, input logic [4:0] r, input logic [15:0] kk,
                    input logic [5:0] qq, input logic [1:0] pp, input cte_amode_e am,
                    input logic [15:0] a, input logic wr);
    logic [7:0] src, got;
    gr(r, src);
    ex(o, d, r, kk, qq, 3'h0, pp, am);
    chk(ncyc, 16'h0002, "transfer cycles");
    chk({8'h00, status_flags}, 16'h0040, "flags kept");
    chk(dm_seen.addr, a, "data address");
    if (wr) chk({7'h00, dm_seen.we, dm_seen.wdata}, {8'h01, src}, "store data");
    else begin
      gr(d, got);
      chk({7'h00, dm_seen.re, got}, {8'h01, dval(a)}, "load data");
    end
  endtask : xf

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run takes a few hundred cycles, so 40000 means a hang
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ins_valid = 1'b0;
    ins = '0;
    dbg_sel = 5'h00;
    {dmem_rdata, io_rdata, pmem_rdata, pmem_done, done_d} = '0;
    {dm_seen, io_seen, pm_seen} = '0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    chk(pc, PC_RESET, "pc reset");
    chk(sp, SP_RESET, "sp reset");
    chk({7'h00, ins_ready, status_flags}, {8'h01, STATUS_FLAGS_RESET}, "ready and flags reset");
    $display("test reset done");
    // Raise-any fills the flags one by one, named ops then toggle single flags
    for (int i = 0; i < 8; i++) begin
      ex(OP_FLAG_RAISE_ANY, 5'h00, 5'h00, 16'h0000, 6'h00, 3'(i));
      chk({ncyc[7:0], status_flags}, {8'h01, 8'hFF >> (7 - i)}, "raise any");
    end
    for (int i = 0; i < 8; i++) begin
      ex(cte_op_e'(6'h21 + 6'(2 * i)));
      chk({ncyc[7:0], status_flags}, {8'h01, ~(8'h01 << i)}, "named drop");
      ex(cte_op_e'(6'h20 + 6'(2 * i)));
      chk({ncyc[7:0], status_flags}, 16'h01FF, "named raise");
    end
    $display("test flags done");
    // Branches with interrupts enabled, then disabled with a backward offset
    p = pc;
    ex(OP_BR_ION, 5'h00, 5'h00, 16'h0005);
    chk({pc, ncyc, 8'h00, status_flags}, {p + 16'h0006, 16'h0002, 16'h00FF}, "taken on");
    ex(OP_BR_IOFF, 5'h00, 5'h00, 16'h0005);
    chk({pc, ncyc}, {p + 16'h0007, 16'h0001}, "untaken off");
    for (int i = 7; i >= 0; i--) begin
      ex(OP_FLAG_DROP_ANY, 5'h00, 5'h00, 16'h0000, 6'h00, 3'(i));
      chk({8'h00, status_flags}, {8'h00, 8'hFF >> (8 - i)}, "drop any");
    end
    p = pc;
    ex(OP_BR_ION, 5'h00, 5'h00, 16'h0005);
    chk({pc, ncyc}, {p + 16'h0001, 16'h0001}, "untaken on");
    ex(OP_BR_IOFF, 5'h00, 5'h00, 16'h007D);
    chk({pc, ncyc, 8'h00, status_flags}, {p - 16'h0001, 16'h0002, 16'h0000}, "taken off");
    $display("test branch done");
    // Pointers X=0120, Y=0200, Z=0300; T set so kept flags are not all zero
    ex(OP_TFLAG_RAISE);
    li(5'h1A, 8'h20); li(5'h1B, 8'h01); li(5'h1C, 8'h00); li(5'h1D, 8'h02); li(5'h1E, 8'h00); li(5'h1F, 8'h03);
    xf(OP_IND_FETCH, 5'h05, 5'h00, 16'h0000, 6'h00, 2'h0, AM_POSTINC, 16'h0120, 1'b0);
    gp(5'h1A, p); chk(p, 16'h0121, "x after post-inc");
    xf(OP_IND_FETCH, 5'h06, 5'h00, 16'h0000, 6'h00, 2'h1, AM_PREDEC, 16'h01FF, 1'b0);
    gp(5'h1C, p); chk(p, 16'h01FF, "y after pre-dec");
    xf(OP_OFS_FETCH, 5'h07, 5'h00, 16'h0000, 6'h3F, 2'h2, AM_PLAIN, 16'h033F, 1'b0);
    gp(5'h1E, p); chk(p, 16'h0300, "z kept");
    p = pc;
    xf(OP_DIR_FETCH, 5'h08, 5'h00, 16'hFFFF, 6'h00, 2'h0, AM_PLAIN, 16'hFFFF, 1'b0);
    chk(pc, p + 16'h0002, "two-word pc");
    xf(OP_IND_WRITE, 5'h00, 5'h05, 16'h0000, 6'h00, 2'h0, AM_POSTINC, 16'h0121, 1'b1);
    gp(5'h1A, p); chk(p, 16'h0122, "x after store");
    xf(OP_IND_WRITE, 5'h00, 5'h06, 16'h0000, 6'h00, 2'h2, AM_PREDEC, 16'h02FF, 1'b1);
    gp(5'h1E, p); chk(p, 16'h02FF, "z after pre-dec");
    xf(OP_OFS_WRITE, 5'h00, 5'h07, 16'h0000, 6'h01, 2'h1, AM_PLAIN, 16'h0200, 1'b1);
    gp(5'h1C, p); chk(p, 16'h01FF, "y kept");
    xf(OP_DIR_WRITE, 5'h00, 5'h08, 16'h0000, 6'h00, 2'h0, AM_PLAIN, 16'h0000, 1'b1);
    xf(OP_STACK_SAVE, 5'h00, 5'h05, 16'h0000, 6'h00, 2'h0, AM_PLAIN, 16'h00FF, 1'b1);
    chk(sp, 16'h00FE, "sp after save");
    xf(OP_STACK_RESTORE, 5'h09, 5'h00, 16'h0000, 6'h00, 2'h0, AM_PLAIN, 16'h00FF, 1'b0);
    chk(sp, 16'h00FF, "sp after restore");
    $display("test data transfer done");
    // Program-memory byte fetch, implicit R0 form then post-increment form
    ex(OP_CODE_FETCH0);
    gr(5'h00, v); chk({ncyc[7:0], v}, {8'h03, dval(~16'h02FF)}, "code fetch r0");
    ex(OP_CODE_FETCH, 5'h0A, 5'h00, 16'h0000, 6'h00, 3'h0, 2'h2, AM_POSTINC);
    gr(5'h0A, v); chk({ncyc[7:0], v}, {8'h03, dval(~16'h02FF)}, "code fetch rd");
    gp(5'h1E, p); chk(p, 16'h0300, "z after code fetch");
    // Read-modify-write of single I/O bits
    ex(OP_IO_BIT_RAISE, 5'h00, 5'h00, 16'h003F, 6'h00, 3'h0);
    chk({ncyc[1:0], io_seen.addr, io_seen.wdata}, {2'h2, 6'h3F, 8'hFD}, "io bit raise");
    ex(OP_IO_BIT_DROP, 5'h00, 5'h00, 16'h0000, 6'h00, 3'h7);
    chk({ncyc[1:0], io_seen.addr, io_seen.wdata}, {2'h2, 6'h00, 8'h43}, "io bit drop");
    $display("test code and io done");
    // Rotates through carry; flags now T only, V follows N xor C
    ex(OP_CARRY_RAISE); li(5'h0A, 8'h81); ex(OP_ROT_UP, 5'h0A);
    gr(5'h0A, v); chk({v, status_flags}, 16'h0349, "rotate up");
    ex(OP_CARRY_DROP); li(5'h0B, 8'h01); ex(OP_ROT_DOWN, 5'h0B);
    gr(5'h0B, v); chk({v, status_flags}, 16'h004B, "rotate down");
    ex(OP_TFLAG_DROP); li(5'h0C, 8'h10); ex(OP_T_CAPTURE, 5'h00, 5'h0C, 16'h0000, 6'h00, 3'h4);
    chk({ncyc[7:0], status_flags}, 16'h014B, "t capture");
    li(5'h0D, 8'h00); ex(OP_T_DEPOSIT, 5'h0D, 5'h00, 16'h0000, 6'h00, 3'h2);
    gr(5'h0D, v); chk({v, status_flags}, 16'h044B, "t deposit");
    // One-cycle moves and port transfers
    ex(OP_PAIR_COPY, 5'h0E, 5'h0C); gr(5'h0F, v); chk({ncyc[7:0], v}, 16'h0104, "pair copy");
    ex(OP_IO_WRITE, 5'h00, 5'h0F, 16'h0015);
    chk({ncyc[1:0], io_seen.addr, io_seen.wdata}, {2'h1, 6'h15, 8'h04}, "io write");
    ex(OP_IO_READ, 5'h10, 5'h00, 16'h0021); ex(OP_REG_COPY, 5'h11, 5'h10);
    gr(5'h11, v); chk({ncyc[7:0], v, 8'h00, status_flags}, {8'h01, 8'hE2, 16'h004B}, "io read and copy");
    li(5'h12, 8'h80);
    for (int i = 0; i < 4; i++) begin
      ex(sops[i], 5'h12);
      gr(5'h12, v); chk({ncyc[7:0], v}, {8'h01, sexp[i]}, "shift result");
    end
    // Program write of R1:R0 at Z, ended by the writer's done
    li(5'h00, 8'hAB); li(5'h01, 8'hCD); ex(OP_CODE_WRITE);
    chk({pm_seen.wdata, pm_seen.addr, ncyc}, {16'hCDAB, 16'h0300, 16'h0003}, "code write");
    $display("test misc done");
    end_sim();
  end
endmodule : tb
